// ### hw/slbm_pkg.sv
// package of the single-line bus master: register map, field positions, timing
// assumes a 100 MHz mclk and a 1 us slot tick made by an integer divider
package slbm_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] SLBM_CTRL_OFF = 8'h00;
  localparam logic [7:0] SLBM_STATUS_OFF = 8'h04;
  localparam logic [7:0] SLBM_DIV_OFF = 8'h08;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SLBM_RESET_PRESENCE_REQUEST_BIT = 0;
  localparam int SLBM_WRITE_ZERO_REQUEST_BIT = 1;
  localparam int SLBM_WRITE_ONE_READ_REQUEST_BIT = 2;
  localparam int SLBM_PRESENCE_STATUS_BIT = 0;
  localparam int SLBM_READ_VALUE_STATUS_BIT = 1;
  localparam int SLBM_BUSY_BIT = 2;

  // ----------------------------------------------------------------
  // clock and tick
  // ----------------------------------------------------------------
  localparam int SLBM_MCLK_MHZ = 100;
  localparam int SLBM_TICK_MHZ = 1;
  localparam logic [7:0] SLBM_DIV_RESET = 8'(SLBM_MCLK_MHZ / SLBM_TICK_MHZ);

  // ----------------------------------------------------------------
  // timing, in microseconds; one tick is one microsecond
  // ----------------------------------------------------------------
  localparam int SLBM_RESET_LOW_TIME_US = 490;
  localparam int SLBM_PRESENCE_SAMPLE_US = 70;
  localparam int SLBM_RESET_HIGH_TIME_US = 490;
  localparam int SLBM_WRITE_ZERO_LOW_US = 100;
  localparam int SLBM_SLOT_TIME_US = 117;
  localparam int SLBM_READ_LOW_US = 5;
  localparam int SLBM_READ_SAMPLE_US = 14;

  localparam int SLBM_US_TICKS = SLBM_TICK_MHZ;
  localparam logic [9:0] SLBM_RESET_LOW_TICKS = 10'(SLBM_RESET_LOW_TIME_US * SLBM_US_TICKS);
  localparam logic [9:0] SLBM_PRESENCE_TICKS = 10'(SLBM_PRESENCE_SAMPLE_US * SLBM_US_TICKS);
  localparam logic [9:0] SLBM_RESET_HIGH_TICKS = 10'(SLBM_RESET_HIGH_TIME_US * SLBM_US_TICKS);
  localparam logic [9:0] SLBM_WRITE_ZERO_LOW_TICKS = 10'(SLBM_WRITE_ZERO_LOW_US * SLBM_US_TICKS);
  localparam logic [9:0] SLBM_SLOT_TICKS = 10'(SLBM_SLOT_TIME_US * SLBM_US_TICKS);
  localparam logic [9:0] SLBM_READ_LOW_TICKS = 10'(SLBM_READ_LOW_US * SLBM_US_TICKS);
  localparam logic [9:0] SLBM_READ_SAMPLE_TICKS = 10'(SLBM_READ_SAMPLE_US * SLBM_US_TICKS);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SLBM_IDLE = 5'b00001,
    SLBM_RST_LOW = 5'b00010,
    SLBM_RST_HIGH = 5'b00100,
    SLBM_SLOT_LOW = 5'b01000,
    SLBM_SLOT_REC = 5'b10000
  } slbm_state_t;

endpackage

// ### hw/slbm_master.sv
// single-line bus master: apb register slave plus reset/presence and slot sequencer
// assumes an external pull-up on the line and a synchronous apb master on mclk
// ----------------------------------------------------------------
module slbm_master
  import slbm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // single line, open drain
  input wire logic line_in,
  output logic line_out,
  output logic line_oe
);
  import slbm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  slbm_state_t state;
  slbm_state_t next_state;
  logic [2:0] request;
  logic [2:0] next_request;
  logic presence_status;
  logic read_value_status;
  logic slot_is_read;
  logic [7:0] div_ratio;
  logic [7:0] div_cnt;
  logic tick;
  logic [9:0] us_cnt;
  logic line_meta;
  logic line_sync;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup_phase = psel & ~penable & ~pready;
  // writes land only at the edge where the master sees pready, never in setup
  wire access_done = psel & penable & pready;
  wire wr_ctrl = access_done & pwrite & (paddr == SLBM_CTRL_OFF);
  wire wr_div = access_done & pwrite & (paddr == SLBM_DIV_OFF);
  wire addr_hit = (paddr == SLBM_CTRL_OFF) | (paddr == SLBM_STATUS_OFF) |
                  (paddr == SLBM_DIV_OFF);
  wire busy = (state != SLBM_IDLE);
  wire [31:0] ctrl_word = {29'h0, request};
  wire [31:0] status_word = {29'h0, busy, read_value_status, presence_status};
  wire [31:0] div_word = {24'h0, div_ratio};
  wire [31:0] read_word = (paddr == SLBM_CTRL_OFF) ? ctrl_word :
                          (paddr == SLBM_STATUS_OFF) ? status_word :
                          (paddr == SLBM_DIV_OFF) ? div_word : 32'h0;

  // single wait-free access: pready rises in the first access cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~addr_hit;
      prdata <= (setup_phase & ~pwrite) ? read_word : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // tick divider
  // ----------------------------------------------------------------
  // a ratio of zero behaves as one; the divider restarts with each sequence so the
  // first microsecond of a phase is full length
  wire [7:0] div_last = (div_ratio == 8'h0) ? 8'h0 : div_ratio - 8'h1;
  wire div_wrap = (div_cnt == div_last);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_ratio <= SLBM_DIV_RESET;
    end else if (wr_div) begin
      div_ratio <= pwdata[7:0];
    end
  end

  // tick comes straight from the wrap, so a phase of k us lasts exactly k * ratio cycles;
  // a registered tick would stretch every low phase by one mclk
  assign tick = busy & div_wrap;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_cnt <= 8'h0;
    end else if (!busy) begin
      div_cnt <= 8'h0;
    end else begin
      div_cnt <= div_wrap ? 8'h0 : div_cnt + 8'h1;
    end
  end

  // ----------------------------------------------------------------
  // line input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end else begin
      line_meta <= line_in;
      line_sync <= line_meta;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wire start_rpp = request[SLBM_RESET_PRESENCE_REQUEST_BIT];
  wire start_wr0 = request[SLBM_WRITE_ZERO_REQUEST_BIT];
  wire start_wr1 = request[SLBM_WRITE_ONE_READ_REQUEST_BIT];
  wire [9:0] slot_low_ticks = slot_is_read ? SLBM_READ_LOW_TICKS : SLBM_WRITE_ZERO_LOW_TICKS;
  wire rst_low_done = tick & (us_cnt == SLBM_RESET_LOW_TICKS - 10'd1);
  wire presence_point = tick & (us_cnt == SLBM_PRESENCE_TICKS - 10'd1);
  wire rst_high_done = tick & (us_cnt == SLBM_RESET_HIGH_TICKS - 10'd1);
  wire slot_low_done = tick & (us_cnt == slot_low_ticks - 10'd1);
  wire read_point = tick & (us_cnt == SLBM_READ_SAMPLE_TICKS - 10'd1);
  wire slot_done = tick & (us_cnt == SLBM_SLOT_TICKS - 10'd1);

  always_comb begin
    next_state = state;
    case (state)
      SLBM_IDLE: begin
        // one request at a time; reset/presence has priority over slots
        if (start_rpp) begin
          next_state = SLBM_RST_LOW;
        end else if (start_wr0 | start_wr1) begin
          next_state = SLBM_SLOT_LOW;
        end
      end
      SLBM_RST_LOW: begin
        if (rst_low_done) begin
          next_state = SLBM_RST_HIGH;
        end
      end
      SLBM_RST_HIGH: begin
        if (rst_high_done) begin
          next_state = SLBM_IDLE;
        end
      end
      SLBM_SLOT_LOW: begin
        if (slot_low_done) begin
          next_state = SLBM_SLOT_REC;
        end
      end
      SLBM_SLOT_REC: begin
        if (slot_done) begin
          next_state = SLBM_IDLE;
        end
      end
      default: begin
        next_state = SLBM_IDLE;
      end
    endcase
  end

  // request bits: software writes only take hold while idle, hardware clears them
  always_comb begin
    next_request = request;
    if (wr_ctrl && !busy) begin
      next_request = pwdata[2:0];
    end
    if (state == SLBM_RST_HIGH && presence_point) begin
      next_request[SLBM_RESET_PRESENCE_REQUEST_BIT] = 1'b0;
    end
    if (state == SLBM_SLOT_REC && slot_done) begin
      if (slot_is_read) begin
        next_request[SLBM_WRITE_ONE_READ_REQUEST_BIT] = 1'b0;
      end else begin
        next_request[SLBM_WRITE_ZERO_REQUEST_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= SLBM_IDLE;
      request <= 3'h0;
    end else begin
      state <= next_state;
      request <= next_request;
    end
  end

  // microsecond counter; it runs through both halves of a slot but restarts
  // for the recovery half of a reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      us_cnt <= 10'h0;
    end else if (state == SLBM_IDLE || (state == SLBM_RST_LOW && rst_low_done)) begin
      us_cnt <= 10'h0;
    end else if (tick) begin
      us_cnt <= us_cnt + 10'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      slot_is_read <= 1'b0;
    end else if (state == SLBM_IDLE && !start_rpp && (start_wr0 | start_wr1)) begin
      slot_is_read <= ~start_wr0;
    end
  end

  // ----------------------------------------------------------------
  // status capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      presence_status <= 1'b0;
      read_value_status <= 1'b0;
    end else begin
      if (state == SLBM_RST_HIGH && presence_point) begin
        presence_status <= ~line_sync;
      end
      if (state == SLBM_SLOT_REC && slot_is_read && read_point) begin
        read_value_status <= line_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // line driver
  // ----------------------------------------------------------------
  // only ever pulls low; the pull-up makes the high level
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      line_out <= 1'b0;
      line_oe <= 1'b0;
    end else begin
      line_out <= 1'b0;
      line_oe <= (next_state == SLBM_RST_LOW) || (next_state == SLBM_SLOT_LOW);
    end
  end

endmodule // slbm_master

// ### test/slbm_assertions.sv
// checker for the single-line bus master, bound to its ports
// assumes the divider is only rewritten between sequences
module slbm_assertions
  import slbm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // helper counters, in mclk cycles
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic [9:0] d;
  int unsigned low_cnt;
  int unsigned high_cnt;
  logic after_rst;
  // a zero ratio behaves as one
  assign d = (div_q == 8'h00) ? 10'h001 : {2'h0, div_q};
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_q <= SLBM_DIV_RESET;
      low_cnt <= 0;
      high_cnt <= 0;
      after_rst <= 1'b0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == SLBM_DIV_OFF) div_q <= pwdata[7:0];
      low_cnt <= line_oe ? low_cnt + 1 : 0;
      high_cnt <= line_oe ? 0 : high_cnt + 1;
      if ($fell(line_oe)) after_rst <= (low_cnt >= 400 * d);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  pulldown_only_a: assert property (line_oe |-> !line_out)
    else $error("line driven high");
  zero_slot_len_a: assert property ($fell(line_oe) && low_cnt > 50 * d && low_cnt < 400 * d
    |-> low_cnt > 99 * d && low_cnt <= 100 * d + 1) else $error("write zero low length");
  reset_low_a: assert property ($fell(line_oe) && low_cnt >= 400 * d
    |-> low_cnt >= 480 * d && low_cnt <= 511 * d) else $error("reset low length");
  read_low_a: assert property ($fell(line_oe) && low_cnt <= 50 * d
    |-> low_cnt >= d && low_cnt <= 15 * d) else $error("read slot low length");
  recovery_len_a: assert property ($rose(line_oe) && after_rst |-> high_cnt >= 480 * d)
    else $error("reset recovery short");
  ready_once_a: assert property (pready |=> !pready) else $error("pready too long");
  ready_prompt_a: assert property (psel && !penable |=> pready) else $error("pready late");
  unmapped_err_a: assert property (psel && !penable && paddr > SLBM_DIV_OFF
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata outside access");
  cover property ($fell(line_oe) && low_cnt >= 400 * d);
  cover property ($fell(line_oe) && low_cnt <= 50 * d);
  cover property (pslverr);
endmodule // slbm_assertions

bind slbm_master slbm_assertions i_chk(.mclk(mclk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_out(line_out),
  .line_oe(line_oe));

// ### test/slbm_slave_model.sv
// model of a serial memory slave on the single line
// assumes 1 us equals one mclk cycle (divider written as 1)
module slbm_slave_model (
  // clock
  input wire logic mclk,
  // line and behaviour
  input wire logic line,
  input wire logic present,
  input wire logic read_bit,
  output logic pull_low
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt = 0;
  int pres_t = -1;
  int hold = 0;
  logic line_q = 1'b1;
  always @(posedge mclk) begin
    line_q <= line;
    low_cnt <= line ? 0 : low_cnt + 1;
    if (line && !line_q && low_cnt >= 480 && present) pres_t <= 0;
    else if (pres_t >= 0 && pres_t < 150) pres_t <= pres_t + 1;
    else pres_t <= -1;
    // a zero answer holds the line past the master's release
    if (!line && line_q && !read_bit) hold <= 45;
    else if (hold > 0) hold <= hold - 1;
  end
  assign pull_low = (pres_t >= 30 && pres_t < 150) || hold > 0;
endmodule // slbm_slave_model

// ### test/testbench.sv
// self-checking bench for the single-line bus master
// assumes a pull-up on the line and the slave model beside it
module testbench
  import slbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic present = 1'b1;
  logic read_bit = 1'b1;
  logic [31:0] rv;
  logic re;
  wire [31:0] prdata;
  wire pready, pslverr, line_out, line_oe, pull_low, line;
  int n_errors = 0;
  int total_checks = 0;
  int oe_len = 0;
  int last_len = 0;
  always #5 mclk = ~mclk;
  assign line = !((line_oe && !line_out) || pull_low);
  slbm_master i_dut(.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_in(line), .line_out(line_out), .line_oe(line_oe));
  slbm_slave_model i_slave(.mclk(mclk), .line(line), .present(present),
    .read_bit(read_bit), .pull_low(pull_low));
  always @(posedge mclk) begin
    if (line_oe) oe_len <= oe_len + 1;
    else begin
      if (oe_len != 0) last_len <= oe_len;
      oe_len <= 0;
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rd(SLBM_STATUS_OFF);
      n++;
    end while (rv[SLBM_BUSY_BIT] !== 1'b0 && n < 1000);
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(SLBM_DIV_OFF);
    chk(rv, {24'h0, SLBM_DIV_RESET});
    apb(1'b1, SLBM_STATUS_OFF, 32'h7);
    rd(SLBM_STATUS_OFF);
    chk(rv, 32'h0);
    apb(1'b1, 8'h0c, 32'h1);
    chk(re, 1'b1);
    rd(SLBM_CTRL_OFF);
    chk(rv, 32'h0);
  endtask
  task automatic t_w0(input logic [7:0] dv);
    apb(1'b1, SLBM_DIV_OFF, {24'h0, dv});
    apb(1'b1, SLBM_CTRL_OFF, 32'h2);
    wait_idle();
    chk(last_len, 100 * dv);
    rd(SLBM_CTRL_OFF);
    chk(rv, 32'h0);
  endtask
  task automatic t_init(input logic p);
    present <= p;
    apb(1'b1, SLBM_CTRL_OFF, 32'h1);
    rd(SLBM_CTRL_OFF);
    chk(rv, 32'h1);
    // a second request while busy must be dropped
    apb(1'b1, SLBM_CTRL_OFF, 32'h2);
    rd(SLBM_CTRL_OFF);
    chk(rv, 32'h1);
    wait_idle();
    chk(last_len, SLBM_RESET_LOW_TIME_US);
    chk(rv[SLBM_PRESENCE_STATUS_BIT], p);
    rd(SLBM_CTRL_OFF);
    chk(rv, 32'h0);
  endtask
  task automatic t_rd(input logic b);
    read_bit <= b;
    apb(1'b1, SLBM_CTRL_OFF, 32'h4);
    wait_idle();
    chk(last_len, SLBM_READ_LOW_US);
    chk(rv[SLBM_READ_VALUE_STATUS_BIT], b);
    rd(SLBM_CTRL_OFF);
    chk(rv, 32'h0);
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_w0(8'h02);
    t_w0(8'h01);
    t_init(1'b1);
    t_init(1'b0);
    t_rd(1'b0);
    t_rd(1'b1);
    conclude();
  end
endmodule // testbench
